// ==== hdl/adcs_pkg.sv ====
// Package of constants for the converter channel sequencer.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package adcs_pkg;
   localparam int CLK_MHZ = 20;
   localparam int ADC_MAX_MHZ = 18;
   // Smallest divide that keeps the converter clock at or below its limit.
   localparam int ADC_DIV = (CLK_MHZ + ADC_MAX_MHZ - 1) / ADC_MAX_MHZ;
   localparam int CONV_CLKS = 18;
   localparam int N_CH = 16;
   localparam int BASE_CH = 8;
   localparam int RES_W = 12;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CHEN = 8'h04;
   localparam logic [7:0] OFS_RANGE = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_SAMP_LO = 8'h14;
   localparam logic [7:0] OFS_SAMP_HI = 8'h18;
   localparam logic [7:0] OFS_RES = 8'h40;

   localparam int CTRL_EN = 0;
   localparam int CTRL_SCAN = 1;
   localparam int CTRL_CONT = 2;
   localparam int CTRL_START = 3;
   localparam int CTRL_REF = 4;
   localparam int CTRL_EXT16 = 6;
   localparam int CTRL_FWCH = 8;
   localparam int CTRL_APER = 12;
   localparam int RANGE_HI = 16;
   localparam int STAT_RANGE = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_CH = 8;
   localparam int STAT_BUSY = 16;
   localparam int RES_VALID = 31;

   localparam logic [31:0] CTRL_RST = 32'h0000_0002;
   localparam logic [31:0] CHEN_RST = 32'h0000_00ff;
   localparam logic [31:0] RANGE_RST = 32'h0fff_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] SAMP_RST = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      REF_SUPPLY,
      REF_HALF_SUPPLY,
      REF_BANDGAP,
      REF_EXT
   } adcs_ref_t;
endpackage

// ==== hdl/adcs_conv.sv ====
// Timing of one sample-and-convert cycle towards the analog core.
// Assumes i_adc_ce is a one-cycle enable at the converter clock rate.
`timescale 1ns/1ps
module adcs_conv
   import adcs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_adc_ce,
   input wire logic i_abort,
   input wire logic i_go,
   input wire logic [3:0] i_ch,
   input wire logic [4:0] i_samp,
   input wire logic [RES_W-1:0] i_core_data,
   output logic o_take,
   output logic o_done,
   output logic [3:0] o_ch,
   output logic [RES_W-1:0] o_data,
   output logic [3:0] o_mux_sel,
   output logic o_sample,
   output logic o_convert,
   output logic o_busy
);
   typedef enum logic [1:0] {C_IDLE, C_SAMP, C_CONV} adcs_cst_t;
   adcs_cst_t st_q;
   logic [4:0] cnt_q;
   logic last;
   logic launch;
   logic [4:0] ce_cnt_q;

   assign last = (st_q == C_CONV) && i_adc_ce && (cnt_q == 5'h01);
   // Next channel starts in the cycle the last one ends.
   // Launching on the enable keeps each phase whole converter clocks.
   assign launch = i_go && i_adc_ce && ((st_q == C_IDLE) || last);
   assign o_busy = (st_q != C_IDLE);

   always_ff @(posedge i_clk)
   begin
      if (i_rst || i_abort)
      begin
         st_q <= C_IDLE;
         cnt_q <= 5'h00;
         o_sample <= 1'b0;
         o_convert <= 1'b0;
      end
      else if (launch)
      begin
         st_q <= C_SAMP;
         cnt_q <= i_samp;
         o_mux_sel <= i_ch;
         o_sample <= 1'b1;
         o_convert <= 1'b0;
      end
      else if (last)
      begin
         st_q <= C_IDLE;
         o_convert <= 1'b0;
      end
      else if (i_adc_ce && (st_q != C_IDLE))
      begin
         if ((st_q == C_SAMP) && (cnt_q == 5'h01))
         begin
            // Full conversion spans eighteen converter clocks.
            st_q <= C_CONV;
            cnt_q <= 5'(CONV_CLKS);
            o_sample <= 1'b0;
            o_convert <= 1'b1;
         end
         else
         begin
            cnt_q <= cnt_q - 5'h01;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst || i_abort)
      begin
         o_take <= 1'b0;
         o_done <= 1'b0;
         o_ch <= 4'h0;
         o_data <= 12'h000;
      end
      else
      begin
         o_take <= launch;
         o_done <= last;
         if (last)
         begin
            o_ch <= o_mux_sel;
            o_data <= i_core_data;
         end
      end
   end

   // Helper count of converter clocks spent converting.
   always_ff @(posedge i_clk)
   begin
      if (i_rst || !o_convert)
         ce_cnt_q <= 5'h00;
      else if (i_adc_ce)
         ce_cnt_q <= ce_cnt_q + 5'h01;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_conv_end;
      $fell(o_convert) && !$past(i_abort);
   endsequence
   property p_conv_len;
      s_conv_end |-> (ce_cnt_q == 5'(CONV_CLKS));
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion not eighteen converter clocks");
   sequence s_done_go;
      o_done && $past(i_go) && !$past(i_abort);
   endsequence
   property p_no_gap;
      s_done_go |-> o_take && o_sample;
   endproperty
   a_no_gap: assert property (p_no_gap)
      else $error("idle gap between channels");
endmodule // adcs_conv

// ==== hdl/adcs_seq.sv ====
// Channel sequencer for a 12-bit successive-approximation converter.
// Assumes an AXI4-Lite master and a core that holds its result valid
// on i_core_data by the last converter clock of each conversion.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module adcs_seq
   import adcs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [7:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [7:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_low_power,
   input wire logic [RES_W-1:0] i_core_data,
   output logic [3:0] o_mux_sel,
   output logic o_sample,
   output logic o_convert,
   output logic o_adc_ce,
   output logic [1:0] o_ref_sel,
   output logic o_irq
);
   logic [31:0] ctrl_q, chen_q, range_q, mask_q;
   logic [63:0] samp_q;
   logic [RES_W-1:0] res_q [N_CH];
   logic [N_CH-1:0] res_valid_q;
   logic [1:0] stat_q;
   logic [3:0] range_ch_q;
   logic aw_hold_q, w_hold_q, aw_hold_d, w_hold_d;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q, wmerged;
   logic [3:0] w_strb_q;
   logic aw_fire, w_fire, wr_do, ar_fire;
   logic [7:0] div_q;
   logic run_q;
   logic [3:0] ptr_q, sel_ch;
   logic [N_CH-1:0] chen_eff;
   logic [4:0] nxt, first;
   logic [4:0] samp_len;
   logic take, done, busy, start, start_q, oor;
   logic [3:0] done_ch;
   logic [RES_W-1:0] done_data, lo_b, hi_b;

   function automatic logic reg_ok(input logic [7:0] a);
      reg_ok = (a[1:0] == 2'h0) && ((a <= OFS_SAMP_HI) ||
         ((a >= OFS_RES) && (a < OFS_RES + 8'(4 * N_CH))));
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      int b;
      merge = o;
      for (b = 0; b < 4; b++)
         if (s[b])
            merge[b*8 +: 8] = n[b*8 +: 8];
   endfunction

   // Returns {wrapped, channel} of the next enabled channel after p.
   function automatic logic [4:0] next_en(input logic [3:0] p,
      input logic [N_CH-1:0] m);
      int i;
      logic [3:0] idx;
      logic hit;
      next_en = {1'b1, p};
      hit = 1'b0;
      for (i = 1; i <= N_CH; i++)
      begin
         idx = 4'(p + 4'(i));
         if (m[idx] && !hit)
         begin
            next_en = {(idx <= p), idx};
            hit = 1'b1;
         end
      end
   endfunction

   assign aw_fire = i_awvalid && o_awready;
   assign w_fire = i_wvalid && o_wready;
   assign wr_do = aw_hold_q && w_hold_q && !o_bvalid;
   assign ar_fire = i_arvalid && o_arready;
   assign wmerged = merge(32'h0, w_data_q, w_strb_q);
   assign aw_hold_d = aw_fire || (aw_hold_q && !wr_do);
   assign w_hold_d = w_fire || (w_hold_q && !wr_do);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end
      else
      begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         o_awready <= !aw_hold_d;
         o_wready <= !w_hold_d;
         if (aw_fire)
            aw_addr_q <= i_awaddr;
         if (w_fire)
         begin
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end
      else if (wr_do)
      begin
         o_bvalid <= 1'b1;
         o_bresp <= reg_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_bready)
         o_bvalid <= 1'b0;
   end

   // Configuration registers; start is a pulse and is not stored.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ctrl_q <= CTRL_RST;
         chen_q <= CHEN_RST;
         range_q <= RANGE_RST;
         mask_q <= MASK_RST;
         samp_q <= {SAMP_RST, SAMP_RST};
      end
      else if (wr_do)
      begin
         unique case (aw_addr_q)
            OFS_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) &
               ~(32'h1 << CTRL_START);
            OFS_CHEN: chen_q <= merge(chen_q, w_data_q, w_strb_q);
            OFS_RANGE: range_q <= merge(range_q, w_data_q, w_strb_q);
            OFS_MASK: mask_q <= merge(mask_q, w_data_q, w_strb_q);
            OFS_SAMP_LO: samp_q[31:0] <= merge(samp_q[31:0], w_data_q,
               w_strb_q);
            OFS_SAMP_HI: samp_q[63:32] <= merge(samp_q[63:32], w_data_q,
               w_strb_q);
            default: ;
         endcase
      end
   end

   assign start = wr_do && (aw_addr_q == OFS_CTRL) && wmerged[CTRL_START];

   // Start acts a cycle late so that it sees the control word it came with.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         start_q <= 1'b0;
      else
         start_q <= start;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= RESP_OKAY;
      end
      else
      begin
         o_arready <= !(ar_fire || (o_rvalid && !i_rready));
         if (ar_fire)
         begin
            o_rvalid <= 1'b1;
            o_rresp <= reg_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            o_rdata <= 32'h0;
            if (i_araddr >= OFS_RES && reg_ok(i_araddr))
               o_rdata <= {res_valid_q[i_araddr[5:2]], 19'h0,
                  res_q[i_araddr[5:2]]};
            else
               unique case (i_araddr)
                  OFS_CTRL: o_rdata <= ctrl_q;
                  OFS_CHEN: o_rdata <= chen_q;
                  OFS_RANGE: o_rdata <= range_q;
                  OFS_STAT: o_rdata <= {15'h0, busy, 4'h0, range_ch_q,
                     6'h0, stat_q};
                  OFS_MASK: o_rdata <= mask_q;
                  OFS_SAMP_LO: o_rdata <= samp_q[31:0];
                  OFS_SAMP_HI: o_rdata <= samp_q[63:32];
                  default: ;
               endcase
         end
         else if (i_rready)
            o_rvalid <= 1'b0;
      end
   end

   // Converter clock enable kept at or below 18 MHz.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         div_q <= 8'h00;
         o_adc_ce <= 1'b0;
      end
      else
      begin
         o_adc_ce <= (div_q == 8'(ADC_DIV - 1));
         div_q <= (div_q == 8'(ADC_DIV - 1)) ? 8'h00 : div_q + 8'h01;
      end
   end

   // Upper eight inputs scanned only when extended.
   assign chen_eff = chen_q[N_CH-1:0] &
      (ctrl_q[CTRL_EXT16] ? 16'hffff : 16'h00ff);
   assign nxt = next_en(ptr_q, chen_eff);
   assign first = next_en(4'hf, chen_eff);
   // Channel source picked by the scan mode bit.
   assign sel_ch = ctrl_q[CTRL_SCAN] ? ptr_q : ctrl_q[CTRL_FWCH +: 4];
   // Aperture plus the channel's own sample time plus one converter clock.
   assign samp_len = 5'(ctrl_q[CTRL_APER +: 4]) +
      5'(samp_q[sel_ch*4 +: 4]) + 5'h01;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         run_q <= 1'b0;
         ptr_q <= 4'h0;
      end
      else if (i_low_power || !ctrl_q[CTRL_EN])
         run_q <= 1'b0;
      else if (start_q && !run_q)
      begin
         if (!ctrl_q[CTRL_SCAN])
            run_q <= 1'b1;
         else if (|chen_eff)
         begin
            run_q <= 1'b1;
            ptr_q <= first[3:0];
         end
      end
      else if (take && run_q)
      begin
         // Scan advances to the next enabled channel; firmware keeps its channel.
         if (ctrl_q[CTRL_SCAN])
         begin
            ptr_q <= nxt[3:0];
            if (nxt[4] && !ctrl_q[CTRL_CONT])
               run_q <= 1'b0;
         end
         else if (!ctrl_q[CTRL_CONT])
            run_q <= 1'b0;
      end
   end

   adcs_conv u_conv (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_adc_ce(o_adc_ce),
      .i_abort(i_low_power),
      .i_go(run_q),
      .i_ch(sel_ch),
      .i_samp(samp_len),
      .i_core_data(i_core_data),
      .o_take(take),
      .o_done(done),
      .o_ch(done_ch),
      .o_data(done_data),
      .o_mux_sel(o_mux_sel),
      .o_sample(o_sample),
      .o_convert(o_convert),
      .o_busy(busy)
   );

   assign lo_b = range_q[RES_W-1:0];
   assign hi_b = range_q[RANGE_HI +: RES_W];
   assign oor = (done_data < lo_b) || (done_data > hi_b);

   // Latest result per channel; a read clears valid, a new one wins.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         res_valid_q <= '0;
      else
      begin
         if (ar_fire && reg_ok(i_araddr) && i_araddr >= OFS_RES)
            res_valid_q[i_araddr[5:2]] <= 1'b0;
         if (done)
            res_valid_q[done_ch] <= 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (done)
         res_q[done_ch] <= done_data;
   end

   // Sticky flags, read clears, new event wins.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         stat_q <= 2'h0;
         range_ch_q <= 4'h0;
      end
      else
      begin
         if (ar_fire && i_araddr == OFS_STAT)
            stat_q <= 2'h0;
         if (done && oor)
         begin
            stat_q[STAT_RANGE] <= 1'b1;
            range_ch_q <= done_ch;
         end
         if (done && !run_q)
            stat_q[STAT_DONE] <= 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_irq <= 1'b0;
         o_ref_sel <= REF_SUPPLY;
      end
      else
      begin
         o_irq <= |(stat_q & mask_q[1:0]);
         // Reference choice driven to the core.
         o_ref_sel <= ctrl_q[CTRL_REF +: 2];
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_ce_rate;
      o_adc_ce |=> !o_adc_ce;
   endproperty
   a_ce_rate: assert property (p_ce_rate)
      else $error("converter clock above limit");
   property p_scan_en;
      take && ctrl_q[CTRL_SCAN] && $stable(chen_eff) |->
         chen_eff[o_mux_sel];
   endproperty
   a_scan_en: assert property (p_scan_en)
      else $error("scan took a disabled channel");
   property p_fw_ch;
      take && !ctrl_q[CTRL_SCAN] && $stable(ctrl_q) |->
         o_mux_sel == ctrl_q[CTRL_FWCH +: 4];
   endproperty
   a_fw_ch: assert property (p_fw_ch)
      else $error("firmware channel not used");
   property p_buf;
      done |=> res_valid_q[$past(done_ch)] &&
         res_q[$past(done_ch)] == $past(done_data);
   endproperty
   a_buf: assert property (p_buf)
      else $error("result not buffered");
   sequence s_oor;
      done && oor;
   endsequence
   property p_oor_irq;
      s_oor |=> stat_q[STAT_RANGE] && range_ch_q == $past(done_ch)
         ##1 (o_irq || !mask_q[STAT_RANGE]);
   endproperty
   a_oor_irq: assert property (p_oor_irq)
      else $error("out-of-range not flagged");
   property p_in_range;
      done && !oor && !stat_q[STAT_RANGE] |=> !stat_q[STAT_RANGE];
   endproperty
   a_in_range: assert property (p_in_range)
      else $error("in-range result flagged");
   property p_sleep;
      i_low_power |=> !o_sample && !o_convert && !run_q;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("converter active in low power");
endmodule // adcs_seq

// ==== tb/adcs_core_model.sv ====
// Behavioural analog converter core with its input multiplexer.
// Assumes the sequencer holds the mux select steady while converting.
`timescale 1ns/1ps
module adcs_core_model
   import adcs_pkg::*;
(
   input wire logic i_clk,
   input wire logic [3:0] i_mux_sel,
   input wire logic i_convert,
   output logic [RES_W-1:0] o_data
);
   initial o_data = 12'h000;
   // Outside a conversion the output flips so stale data never matches.
   always @(posedge i_clk)
   begin
      if (i_convert)
         o_data <= {i_mux_sel, 8'h10};
      else
         o_data <= ~o_data;
   end
endmodule // adcs_core_model

// ==== tb/tb.sv ====
// Self-checking bench for the converter channel sequencer.
// Assumes the behavioural core model on the analog side.
`timescale 1ns/1ps
module tb
   import adcs_pkg::*;
();
   logic clk, rst = 1'b1, lp = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, sample, convert;
   logic adc_ce;
   logic [1:0] bresp, rresp, ref_sel;
   logic [31:0] rdata;
   logic [3:0] mux_sel;
   logic [RES_W-1:0] core_data;
   int mismatches = 0, checked = 0, s_cnt = 0, c_cnt = 0, b2b = 0, ce_n = 0;
   logic s_p = 1'b0, c_p = 1'b0;
   int smp_q[$], cnv_q[$];
   logic [3:0] ch_q[$];

   adcs_seq DUT (.i_clk(clk), .i_rst(rst), .i_awvalid(awvalid),
      .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
      .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
      .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
      .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
      .o_rresp(rresp), .i_low_power(lp), .i_core_data(core_data),
      .o_mux_sel(mux_sel), .o_sample(sample), .o_convert(convert),
      .o_adc_ce(adc_ce), .o_ref_sel(ref_sel), .o_irq(irq));

   adcs_core_model CORE (.i_clk(clk), .i_mux_sel(mux_sel),
      .i_convert(convert), .o_data(core_data));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Logs each sample and convert phase away from the active edge.
   always @(negedge clk)
   begin
      if (sample) s_cnt++;
      if (convert) c_cnt++;
      if (adc_ce) ce_n++;
      if (s_p && !sample)
      begin
         smp_q.push_back(s_cnt);
         ch_q.push_back(mux_sel);
         s_cnt = 0;
      end
      if (c_p && !convert)
      begin
         cnv_q.push_back(c_cnt);
         c_cnt = 0;
         if (sample) b2b++;
      end
      s_p = sample;
      c_p = convert;
   end

   task automatic final_report;
      $display("compares %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic tmo;
      mismatches++;
      $display("ERROR %0t: wait limit reached", $time);
      final_report();
   endtask

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_num(input int g, input int e);
      checked++;
      if (g != e)
      begin
         mismatches++;
         $display("ERROR %0t: count %0d expected %0d", $time, g, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic clr;
      smp_q.delete();
      cnv_q.delete();
      ch_q.delete();
      s_cnt = 0;
      c_cnt = 0;
      b2b = 0;
      ce_n = 0;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      int n;
      n = 0;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
         if (n > 100) tmo();
      end while (awvalid || wvalid || !bvalid);
      chk_word({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
      output logic [31:0] d);
      int n;
      n = 0;
      arvalid <= 1'b1;
      araddr <= a;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
         if (n > 100) tmo();
      end while (arvalid || !rvalid);
      d = rdata;
      chk_word({30'h0, rresp}, {30'h0, er});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      axi_rd(a, RESP_OKAY, rd);
      chk_word(rd, e);
   endtask

   task automatic wait_conv(input int n);
      int k;
      k = 0;
      while (cnv_q.size() < n)
      begin
         @(posedge clk);
         k++;
         if (k > 5000) tmo();
      end
   endtask

   function automatic logic [31:0] res_exp(input int c);
      return 32'h8000_0010 | (32'(c) << 8);
   endfunction

   initial
   begin
      tick(2);
      rst <= 1'b0;
      rd_chk(OFS_CTRL, CTRL_RST);
      rd_chk(OFS_CHEN, CHEN_RST);
      rd_chk(OFS_RANGE, RANGE_RST);
      rd_chk(OFS_MASK, MASK_RST);
      axi_rd(8'h20, RESP_SLVERR, rd);
      chk_word(rd, 32'h0);
      axi_rd(8'h80, RESP_SLVERR, rd);
      chk_word(rd, 32'h0);
      axi_wr(8'h24, 32'hffff_ffff, RESP_SLVERR);
      $display("test registers done");
      for (int r = 0; r < 4; r++)
      begin
         axi_wr(OFS_CTRL, 32'(r) << CTRL_REF, RESP_OKAY);
         tick(2);
         chk_word({30'h0, ref_sel}, 32'(r));
         rd_chk(OFS_CTRL, 32'(r) << CTRL_REF);
      end
      $display("test reference done");
      axi_wr(OFS_CHEN, 32'h0000_000f, RESP_OKAY);
      axi_wr(OFS_RANGE, 32'h0710_0110, RESP_OKAY);
      axi_wr(OFS_SAMP_LO, 32'h7654_3210, RESP_OKAY);
      axi_wr(OFS_MASK, 32'h1, RESP_OKAY);
      clr();
      axi_wr(OFS_CTRL, 32'h0000_100b, RESP_OKAY);
      wait_conv(1);
      tick(4);
      chk_word({31'h0, irq}, 32'h1);
      chk_num(cnv_q.size(), 1);
      wait_conv(4);
      tick(60);
      for (int k = 0; k < 4; k++)
      begin
         chk_word({28'h0, ch_q[k]}, 32'(k));
         chk_num(smp_q[k], (2 + k) * ADC_DIV);
         chk_num(cnv_q[k], CONV_CLKS * ADC_DIV);
         rd_chk(OFS_RES + 8'(4 * k), res_exp(k));
      end
      chk_num(b2b, 3);
      chk_num(cnv_q.size(), 4);
      rd_chk(OFS_STAT, 32'h0000_0003);
      tick(3);
      chk_word({31'h0, irq}, 32'h0);
      rd_chk(OFS_STAT, 32'h0);
      rd_chk(OFS_RES, 32'h0000_0010);
      $display("test scan done");
      axi_wr(OFS_MASK, 32'h0, RESP_OKAY);
      axi_wr(OFS_CHEN, 32'h0000_8002, RESP_OKAY);
      axi_wr(OFS_SAMP_HI, 32'h5000_0000, RESP_OKAY);
      clr();
      axi_wr(OFS_CTRL, 32'h0000_004b, RESP_OKAY);
      wait_conv(2);
      tick(60);
      chk_num(cnv_q.size(), 2);
      chk_word({28'h0, ch_q[1]}, 32'hf);
      chk_num(smp_q[0], 2 * ADC_DIV);
      chk_num(smp_q[1], 6 * ADC_DIV);
      chk_word({31'h0, irq}, 32'h0);
      axi_wr(OFS_MASK, 32'h1, RESP_OKAY);
      tick(3);
      chk_word({31'h0, irq}, 32'h1);
      rd_chk(OFS_STAT, 32'h0000_0f03);
      $display("test extended scan done");
      for (int c = 1; c < 8; c += 6)
      begin
         clr();
         axi_wr(OFS_CTRL, 32'h9 | (32'(c) << CTRL_FWCH), RESP_OKAY);
         wait_conv(1);
         tick(60);
         chk_num(cnv_q.size(), 1);
         chk_word({28'h0, ch_q[0]}, 32'(c));
         rd_chk(OFS_STAT, 32'h0000_0f02);
         rd_chk(OFS_RES + 8'(4 * c), res_exp(c));
      end
      $display("test firmware done");
      axi_wr(OFS_CHEN, 32'h1, RESP_OKAY);
      clr();
      axi_wr(OFS_CTRL, 32'h0000_000f, RESP_OKAY);
      wait_conv(1);
      lp <= 1'b1;
      tick(4);
      clr();
      tick(40);
      chk_num(s_cnt + c_cnt + smp_q.size(), 0);
      chk_num(ce_n, 40 / ADC_DIV);
      axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
      lp <= 1'b0;
      $display("test low power done");
      final_report();
   end
endmodule // tb
